// ===== logic/irq_core.sv
// Core interrupt recognition, priority ordering and response sequencing
//
// Summary of operation
// RULE1 - Software trap vectors through any type 0..255
// RULE2 - Software trap leaves hardware source status alone
// RULE3 - Only maskable request gated by enable flag
// RULE4 - Recognise pending requests only at instruction boundaries
// RULE5 - Recognition delay bounded by 69-clock longest instruction
// RULE6 - Maskable request waits pending while enable clear
// RULE7 - No recognition while bus held by master
// RULE8 - Defer recognition until established numerics instruction ends
// RULE9 - Boundary after segment load is not valid
// RULE10 - String iterations interruptible, restore only last prefix
// RULE11 - Wait instruction interruptible, return to wait
// RULE12 - Maskable type fetched from controller; others self-typed
// RULE13 - Self-typed response follows fixed 42-clock sequence
// RULE14 - On-chip master may use idle response slots
// RULE15 - Non-maskable beats maskable at same boundary
// RULE16 - At most exception plus single step per boundary
// RULE17 - Exception vectored before coincident non-maskable vector
// RULE18 - Non-maskable interrupts at any valid boundary
// RULE19 - Interrupt vector first, single step vector after
// RULE20 - Restored trap flag steps the interrupt routine too
// RULE21 - Push flags, clear trap/enable, push segment and pointer
// RULE22 - Vector entry address is four times type
// RULE23 - Non-maskable uses internal type two
// RULE24 - Single step type one after trap-flag instruction
// RULE25 - All-pending case ordered by combined pairwise priorities
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
module irq_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Execution unit
  input wire logic boundary_i,
  input wire logic seg_load_i,
  input wire logic str_iter_i,
  input wire logic wait_instr_i,
  input wire logic numerics_busy_i,
  input wire logic exc_req_i,
  input wire logic [7:0] exc_type_i,
  input wire logic exc_soft_i,
  input wire logic trap_flag_i,
  input wire logic int_enable_i,
  input wire logic hold_i,
  output logic busy_o,
  // Response sequence towards the bus unit
  output logic [3:0] step_o,
  output logic step_active_o,
  output logic clear_flags_o,
  output logic vec_done_o,
  output logic [7:0] vec_type_o,
  output logic [9:0] vec_addr_o,
  output logic ret_to_wait_o,
  output logic ret_one_prefix_o,
  // On-chip bus master sharing idle slots
  input wire logic share_req_i,
  output logic share_gnt_o,
  // Non-maskable pin, asynchronous
  input wire logic nmi_pin_i,
  output logic nmi_ack_o,
  // Interrupt controller
  input wire logic mask_req_i,
  output logic type_req_o,
  input wire logic type_valid_i,
  input wire logic [7:0] type_i
);
  // ==========================================================
  // Step length lookup
  function automatic logic [2:0] step_len(input logic [3:0] s);
    case (s)
      4'h0: step_len = irq_core_pkg::IDLE0_CLKS;
      4'h1: step_len = irq_core_pkg::RD_IP_CLKS;
      4'h2: step_len = irq_core_pkg::IDLE1_CLKS;
      4'h3: step_len = irq_core_pkg::RD_CS_CLKS;
      4'h4: step_len = irq_core_pkg::IDLE2_CLKS;
      4'h5: step_len = irq_core_pkg::PUSH_FL_CLKS;
      4'h6: step_len = irq_core_pkg::IDLE3_CLKS;
      4'h7: step_len = irq_core_pkg::PUSH_CS_CLKS;
      4'h8: step_len = irq_core_pkg::PUSH_IP_CLKS;
      default: step_len = irq_core_pkg::IDLE4_CLKS;
    endcase
  endfunction : step_len

  function automatic logic is_idle_step(input logic [3:0] s);
    is_idle_step = (s == irq_core_pkg::STEP_IDLE0) || (s == irq_core_pkg::STEP_IDLE1) ||
      (s == irq_core_pkg::STEP_IDLE2) || (s == irq_core_pkg::STEP_IDLE3) ||
      (s == irq_core_pkg::STEP_IDLE4);
  endfunction : is_idle_step

  // ==========================================================
  // Non-maskable pin synchroniser and edge latch
  logic nmi_s1_r, nmi_s2_r, nmi_s3_r, nmi_lvl_r, nmi_pend_r;
  wire nmi_lvl_nxt = (nmi_s2_r == nmi_s3_r) ? nmi_s3_r : nmi_lvl_r;
  wire nmi_rise = nmi_lvl_nxt & ~nmi_lvl_r;
  wire nmi_take;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_s1_r <= 1'b0;
      nmi_s2_r <= 1'b0;
      nmi_s3_r <= 1'b0;
      nmi_lvl_r <= 1'b0;
      nmi_pend_r <= 1'b0;
    end else begin
      nmi_s1_r <= nmi_pin_i;
      nmi_s2_r <= nmi_s1_r;
      nmi_s3_r <= nmi_s2_r;
      nmi_lvl_r <= nmi_lvl_nxt;
      // New edge wins over the clear of the one being taken
      nmi_pend_r <= nmi_rise | (nmi_pend_r & ~nmi_take);
    end
  end

  // ==========================================================
  // Boundary validity
  irq_core_pkg::unit_state_e state_r, state_nxt;
  wire idle = (state_r == irq_core_pkg::ST_IDLE);
  wire blocked = hold_i | numerics_busy_i; // [RULE7] [RULE8]
  // Segment load's own boundary never counts, so paired stack loads stay whole
  wire valid_bnd = boundary_i & idle & ~blocked & ~seg_load_i; // [RULE4] [RULE9]
  wire mask_ok = mask_req_i & int_enable_i; // [RULE3] [RULE6]
  wire any_req = exc_req_i | nmi_pend_r | mask_ok | trap_flag_i;
  wire recog = valid_bnd & any_req;

  // ==========================================================
  // Vector queue captured at a recognised boundary
  // Order taken: exception, non-maskable, maskable, single step
  logic q_exc_r, q_nmi_r, q_mask_r, q_step_r;
  logic [7:0] q_exc_type_r;
  logic cur_soft_r;
  logic [7:0] cur_type_r;
  wire pick_exc = q_exc_r; // [RULE17]
  wire pick_nmi = ~q_exc_r & q_nmi_r; // [RULE15] [RULE18]
  wire pick_mask = ~q_exc_r & ~q_nmi_r & q_mask_r;
  wire pick_step = ~q_exc_r & ~q_nmi_r & ~q_mask_r & q_step_r; // [RULE19] [RULE25]
  wire q_any = q_exc_r | q_nmi_r | q_mask_r | q_step_r;
  assign nmi_take = (state_r == irq_core_pkg::ST_NEXT) & pick_nmi;

  // ==========================================================
  // Sequence counters
  logic [3:0] step_r;
  logic [2:0] clk_cnt_r;
  wire share_en;
  assign share_gnt_o = (state_r == irq_core_pkg::ST_SEQ) & is_idle_step(step_r) &
    share_req_i & share_en; // [RULE14]
  wire step_end = (clk_cnt_r == step_len(step_r) - 3'h1) & ~share_gnt_o;
  wire seq_end = step_end &
    (step_r == 4'(irq_core_pkg::RESP_STEPS - 1)); // [RULE13]

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      irq_core_pkg::ST_IDLE: begin
        if (recog) begin
          state_nxt = irq_core_pkg::ST_NEXT;
        end
      end
      irq_core_pkg::ST_NEXT: begin
        if (!q_any) begin
          state_nxt = irq_core_pkg::ST_IDLE;
        end else if (pick_mask) begin
          state_nxt = irq_core_pkg::ST_TYPE; // [RULE12]
        end else begin
          state_nxt = irq_core_pkg::ST_SEQ;
        end
      end
      irq_core_pkg::ST_TYPE: begin
        if (type_valid_i) begin
          state_nxt = irq_core_pkg::ST_SEQ;
        end
      end
      irq_core_pkg::ST_SEQ: begin
        if (seq_end) begin
          state_nxt = irq_core_pkg::ST_NEXT;
        end
      end
      default: state_nxt = irq_core_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= irq_core_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_exc_r <= 1'b0;
      q_nmi_r <= 1'b0;
      q_mask_r <= 1'b0;
      q_step_r <= 1'b0;
      q_exc_type_r <= 8'h00;
    end else if (state_r == irq_core_pkg::ST_IDLE) begin
      if (recog) begin
        q_exc_r <= exc_req_i; // [RULE16]
        q_exc_type_r <= exc_type_i; // [RULE1]
        q_nmi_r <= nmi_pend_r;
        // Non-maskable vectoring clears the enable flag first
        q_mask_r <= mask_ok & ~nmi_pend_r; // [RULE15]
        q_step_r <= trap_flag_i; // [RULE24] [RULE20]
      end
    end else if (state_r == irq_core_pkg::ST_NEXT) begin
      if (pick_exc) begin
        q_exc_r <= 1'b0;
      end else if (pick_nmi) begin
        q_nmi_r <= 1'b0;
      end else if (pick_mask) begin
        q_mask_r <= 1'b0;
      end else begin
        q_step_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_type_r <= 8'h00;
      cur_soft_r <= 1'b0;
    end else if (state_r == irq_core_pkg::ST_NEXT) begin
      cur_soft_r <= pick_exc & exc_soft_i;
      if (pick_exc) begin
        cur_type_r <= q_exc_type_r;
      end else if (pick_nmi) begin
        cur_type_r <= irq_core_pkg::NMI_TYPE; // [RULE23]
      end else begin
        cur_type_r <= irq_core_pkg::STEP_TYPE;
      end
    end else if ((state_r == irq_core_pkg::ST_TYPE) && type_valid_i) begin
      cur_type_r <= type_i; // [RULE12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_r != irq_core_pkg::ST_SEQ) begin
      step_r <= 4'h0;
      clk_cnt_r <= 3'h0;
    end else if (step_end) begin
      step_r <= step_r + 4'h1;
      clk_cnt_r <= 3'h0;
    end else if (!share_gnt_o) begin
      clk_cnt_r <= clk_cnt_r + 3'h1;
    end
  end

  // ==========================================================
  // Return address qualifiers, captured at recognition
  logic ret_wait_r, ret_prefix_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ret_wait_r <= 1'b0;
      ret_prefix_r <= 1'b0;
    end else if (recog) begin
      ret_wait_r <= wait_instr_i; // [RULE11]
      ret_prefix_r <= str_iter_i; // [RULE10]
    end
  end

  // ==========================================================
  // Outputs to bus unit and execution unit
  logic vec_done_r, clear_r;
  logic [7:0] vec_type_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_done_r <= 1'b0;
      clear_r <= 1'b0;
      vec_type_r <= 8'h00;
    end else begin
      vec_done_r <= seq_end;
      // Flags cleared once saved by the flag push
      clear_r <= (state_r == irq_core_pkg::ST_SEQ) & step_end &
        (step_r == irq_core_pkg::STEP_PUSH_FL); // [RULE21]
      if (seq_end) begin
        vec_type_r <= cur_type_r;
      end
    end
  end

  assign busy_o = ~idle;
  assign step_o = step_r;
  assign step_active_o = (state_r == irq_core_pkg::ST_SEQ);
  assign clear_flags_o = clear_r;
  assign vec_done_o = vec_done_r;
  assign vec_type_o = vec_type_r;
  assign vec_addr_o = {vec_type_r, 2'b00}; // [RULE22]
  assign ret_to_wait_o = ret_wait_r;
  assign ret_one_prefix_o = ret_prefix_r;
  // Hardware status is acknowledged only by hardware vectoring
  assign nmi_ack_o = nmi_take; // [RULE2]
  assign type_req_o = (state_r == irq_core_pkg::ST_TYPE); // [RULE12]

  // ==========================================================
  // Statistics: latency against the longest instruction
  logic [7:0] lat_r;
  logic bound_miss_r;
  logic [7:0] last_resp_r, resp_cnt_r;
  logic [15:0] count_r;
  wire pend = nmi_pend_r | mask_ok | exc_req_i;
  wire bound_clr;

  always_ff @(posedge clk_i) begin
    if (rst_i || !pend || recog || blocked) begin
      lat_r <= 8'h00;
    end else if (lat_r != 8'hff) begin
      lat_r <= lat_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bound_miss_r <= 1'b0;
    end else begin
      // Set wins over software clear
      bound_miss_r <= (lat_r > irq_core_pkg::MAX_INSTR_CLOCKS) |
        (bound_miss_r & ~bound_clr); // [RULE5]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resp_cnt_r <= 8'h00;
      last_resp_r <= 8'h00;
      count_r <= 16'h0000;
    end else begin
      if (state_r == irq_core_pkg::ST_NEXT) begin
        resp_cnt_r <= 8'h00;
      end else if (resp_cnt_r != 8'hff) begin
        resp_cnt_r <= resp_cnt_r + 8'h01;
      end
      if (seq_end) begin
        last_resp_r <= resp_cnt_r + 8'h01;
        count_r <= count_r + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Wishbone slave, one wait cycle, unmapped reads zero
  logic [1:0] ctrl_r;
  logic ack_r, bclr_r;
  logic [31:0] dat_r;
  wire req = wb_cyc_i & wb_stb_i;
  wire wr = req & wb_we_i & ack_r & wb_sel_i[0];
  wire sel_ctrl = (wb_adr_i == irq_core_pkg::CTRL_OFS);
  wire sel_stat = (wb_adr_i == irq_core_pkg::STATUS_OFS);
  wire sel_last = (wb_adr_i == irq_core_pkg::LAST_OFS);
  wire sel_cnt = (wb_adr_i == irq_core_pkg::COUNT_OFS);
  wire [31:0] stat_word = {22'h000000, cur_soft_r, bound_miss_r, state_r,
    q_step_r, q_mask_r, q_nmi_r, q_exc_r, nmi_pend_r, busy_o};
  wire [31:0] rdata = sel_ctrl ? {30'h00000000, ctrl_r} :
    sel_stat ? stat_word :
    sel_last ? {16'h0000, last_resp_r, vec_type_r} :
    sel_cnt ? {16'h0000, count_r} : 32'h00000000;
  assign share_en = ctrl_r[irq_core_pkg::CTRL_SHARE_BIT];
  assign bound_clr = bclr_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
      ctrl_r <= irq_core_pkg::CTRL_RESET;
      bclr_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        dat_r <= rdata;
      end
      bclr_r <= wr & sel_ctrl & wb_dat_i[irq_core_pkg::CTRL_BOUND_CLR_BIT];
      if (wr & sel_ctrl) begin
        ctrl_r <= {1'b0, wb_dat_i[irq_core_pkg::CTRL_SHARE_BIT]};
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
endmodule : irq_core

// ===== logic/irq_core_pkg.sv
// Constants and types for the core interrupt recognition and priority unit
package irq_core_pkg;
  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] LAST_OFS = 4'h8;
  localparam logic [3:0] COUNT_OFS = 4'hc;
  // CTRL fields and reset value
  localparam int CTRL_SHARE_BIT = 0;
  localparam int CTRL_BOUND_CLR_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // ==========================================================
  // Fixed vector types
  localparam logic [7:0] STEP_TYPE = 8'h01;
  localparam logic [7:0] NMI_TYPE = 8'h02;
  // Vector table entry size in bytes, as a shift
  localparam int VEC_ENTRY_SHIFT = 2;
  // Longest instruction, in core clocks
  localparam logic [7:0] MAX_INSTR_CLOCKS = 8'h45;
  // ==========================================================
  // Response sequence: steps and their clock counts (total 42)
  typedef enum logic [3:0] {
    STEP_IDLE0 = 4'h0, STEP_RD_IP = 4'h1, STEP_IDLE1 = 4'h2, STEP_RD_CS = 4'h3,
    STEP_IDLE2 = 4'h4, STEP_PUSH_FL = 4'h5, STEP_IDLE3 = 4'h6, STEP_PUSH_CS = 4'h7,
    STEP_PUSH_IP = 4'h8, STEP_IDLE4 = 4'h9
  } resp_step_e;
  localparam int RESP_STEPS = 10;
  localparam logic [2:0] IDLE0_CLKS = 3'h5;
  localparam logic [2:0] RD_IP_CLKS = 3'h4;
  localparam logic [2:0] IDLE1_CLKS = 3'h5;
  localparam logic [2:0] RD_CS_CLKS = 3'h4;
  localparam logic [2:0] IDLE2_CLKS = 3'h4;
  localparam logic [2:0] PUSH_FL_CLKS = 3'h4;
  localparam logic [2:0] IDLE3_CLKS = 3'h3;
  localparam logic [2:0] PUSH_CS_CLKS = 3'h4;
  localparam logic [2:0] PUSH_IP_CLKS = 3'h4;
  localparam logic [2:0] IDLE4_CLKS = 3'h5;
  // ==========================================================
  // Unit state, Gray along idle -> type fetch -> sequence -> next
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TYPE = 2'b01,
    ST_SEQ = 2'b11,
    ST_NEXT = 2'b10
  } unit_state_e;
endpackage : irq_core_pkg

// ===== verification/irq_core_properties.sv
// Concurrent checks on the interrupt recognition unit ports
`timescale 1ns/100ps
module irq_core_properties (
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Recognition
  input wire logic boundary_i,
  input wire logic hold_i,
  input wire logic numerics_busy_i,
  input wire logic busy_o,
  // Response sequence
  input wire logic [3:0] step_o,
  input wire logic step_active_o,
  input wire logic vec_done_o,
  input wire logic [7:0] vec_type_o,
  input wire logic [9:0] vec_addr_o,
  input wire logic share_req_i,
  input wire logic share_gnt_o,
  input wire logic nmi_ack_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // Counts sequence cycles; granted slots are frozen, so left out
  logic [7:0] seq_cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || !step_active_o) begin
      seq_cnt_r <= 8'h00;
    end else if (!share_gnt_o) begin
      seq_cnt_r <= seq_cnt_r + 8'h01;
    end
  end
  // ==========
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  boundary_only_a: assert property ($rose(busy_o) |-> $past(boundary_i))
    else $error("recognition without a boundary");
  hold_block_a: assert property (boundary_i && hold_i && !busy_o |=> !busy_o)
    else $error("recognised during hold");
  numerics_block_a: assert property (boundary_i && numerics_busy_i && !busy_o |=> !busy_o)
    else $error("recognised during numerics instruction");
  seq_len_a: assert property ($fell(step_active_o) |-> seq_cnt_r == 8'h2a)
    else $error("response sequence length wrong");
  step_first_a: assert property ($rose(step_active_o) |-> step_o == 4'h0)
    else $error("sequence does not start at first step");
  step_order_a: assert property (step_active_o && $past(step_active_o)
    && step_o != $past(step_o) |-> step_o == $past(step_o) + 4'h1)
    else $error("sequence steps out of order");
  share_slot_a: assert property (share_gnt_o && step_active_o |-> share_req_i
    && step_o inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h9})
    else $error("shared slot granted outside an idle step");
  nmi_vec_a: assert property (nmi_ack_o |-> ##[43:300]
    (vec_done_o && vec_type_o == irq_core_pkg::NMI_TYPE))
    else $error("non-maskable vector not completed with its type");
  vec_addr_a: assert property (vec_done_o |-> vec_addr_o == {vec_type_o, 2'h0})
    else $error("vector table address wrong");
endmodule : irq_core_properties

bind irq_core irq_core_properties u_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .boundary_i, .hold_i, .numerics_busy_i,
  .busy_o, .step_o, .step_active_o, .vec_done_o, .vec_type_o, .vec_addr_o, .share_req_i,
  .share_gnt_o, .nmi_ack_o
);

// ===== verification/irq_ctrl_model.sv
// Interrupt controller model: one maskable request and its type
`timescale 1ns/100ps
module irq_ctrl_model (
  // Clock, reset, bench control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic raise_i,
  input wire logic slow_i,
  input wire logic [7:0] vtype_i,
  // Core side
  input wire logic type_req_i,
  output logic mask_req_o,
  output logic type_valid_o,
  output logic [7:0] type_o
);
  logic [2:0] wait_r;
  always_ff @(posedge clk_i) begin
    type_valid_o <= 1'h0;
    // Type bus toggles outside the valid cycle so stale values never match
    type_o <= ~type_o;
    if (rst_i) begin
      mask_req_o <= 1'h0;
      wait_r <= 3'h0;
      type_o <= 8'h5a;
    end else if (raise_i) begin
      mask_req_o <= 1'h1;
    end else if (type_req_i && mask_req_o && !type_valid_o) begin
      wait_r <= wait_r + 3'h1;
      if (wait_r == (slow_i ? 3'h5 : 3'h0)) begin
        type_valid_o <= 1'h1;
        type_o <= vtype_i;
        mask_req_o <= 1'h0;
        wait_r <= 3'h0;
      end
    end
  end
endmodule : irq_ctrl_model

// ===== verification/tb_irq_core.sv
// Self-checking bench for the interrupt recognition unit
`timescale 1ns/100ps
module tb_irq_core;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, boundary_i, seg_load_i;
  logic str_iter_i, wait_instr_i, numerics_busy_i, exc_req_i, exc_soft_i, trap_flag_i;
  logic int_enable_i, hold_i, busy_o, step_active_o, clear_flags_o, vec_done_o, nmi_pin_i;
  logic ret_to_wait_o, ret_one_prefix_o, share_req_i, share_gnt_o, nmi_ack_o, mask_req_i;
  logic type_req_o, type_valid_i, raise, slow, nmi_left;
  logic [3:0] wb_adr_i, wb_sel_i, step_o;
  logic [7:0] exc_type_i, vec_type_o, type_i, mtype, last_t;
  logic [9:0] vec_addr_o;
  logic [31:0] wb_dat_i, wb_dat_o, lf, lf_s, rd;
  logic [3:0] adrs [5] = '{irq_core_pkg::CTRL_OFS, irq_core_pkg::STATUS_OFS,
    irq_core_pkg::LAST_OFS, irq_core_pkg::COUNT_OFS, 4'h2};
  int fail_count, check_count, cnt_exp, cyc;

  irq_core u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .boundary_i, .seg_load_i, .str_iter_i, .wait_instr_i,
    .numerics_busy_i, .exc_req_i, .exc_type_i, .exc_soft_i, .trap_flag_i, .int_enable_i,
    .hold_i, .busy_o, .step_o, .step_active_o, .clear_flags_o, .vec_done_o, .vec_type_o,
    .vec_addr_o, .ret_to_wait_o, .ret_one_prefix_o, .share_req_i, .share_gnt_o, .nmi_pin_i,
    .nmi_ack_o, .mask_req_i, .type_req_o, .type_valid_i, .type_i);
  irq_ctrl_model u_ctrl (.clk_i, .rst_i, .raise_i(raise), .slow_i(slow), .vtype_i(mtype),
    .type_req_i(type_req_o), .mask_req_o(mask_req_i), .type_valid_o(type_valid_i),
    .type_o(type_i));

  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  // ==========
  // Random sharing requests; long timeout ends a hang
  always @(posedge clk_i) begin
    lf_s <= lfsr(lf_s);
    share_req_i <= lf_s[3] & lf_s[9];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Vector order: exception, then NMI (masking the maskable), then step
  function automatic logic [42:0] exp_seq(input logic e, n, m, s, input logic [7:0] et, mt);
    int k;
    logic [39:0] v;
    k = 0;
    v = '0;
    if (e) v[8*k +: 8] = et;
    k += e;
    if (n) v[8*k +: 8] = irq_core_pkg::NMI_TYPE;
    else if (m) v[8*k +: 8] = mt;
    k += n | m;
    if (s) v[8*k +: 8] = irq_core_pkg::STEP_TYPE;
    k += s;
    return {k[2:0], v};
  endfunction : exp_seq

  task automatic chk_reg(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_vec(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_vec

  task automatic wb(input logic we, input logic [3:0] adr, sel, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, adr, sel, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb

  // Qualifiers in blk: wait, string, then the blocking hold, numerics, segment load
  task automatic run(input logic e, n, m, s, input logic [7:0] et, mt, input logic [4:0] blk);
    logic [42:0] x;
    int k, c;
    x = (blk[2:0] != 3'h0) ? 43'h0 : exp_seq(e, n | nmi_left, m, s, et, mt);
    nmi_left = (blk[2:0] != 3'h0) & (n | nmi_left);
    if (n) begin
      nmi_pin_i <= 1'h1;
      // Two cycles high, so the pin filter sees its stages agree
      repeat (2) @(posedge clk_i);
      nmi_pin_i <= 1'h0;
      repeat (6) @(posedge clk_i);
    end
    if (m) begin
      {raise, mtype, slow} <= {1'h1, mt, lf[0]};
      @(posedge clk_i);
      raise <= 1'h0;
      @(posedge clk_i);
    end
    {exc_req_i, exc_soft_i, exc_type_i, trap_flag_i, int_enable_i} <= {e, e, et, s, m};
    {wait_instr_i, str_iter_i, hold_i, numerics_busy_i, seg_load_i} <= blk;
    boundary_i <= 1'h1;
    @(posedge clk_i);
    {boundary_i, exc_req_i, trap_flag_i} <= 3'h0;
    {wait_instr_i, str_iter_i, hold_i, numerics_busy_i, seg_load_i} <= 5'h00;
    k = 0;
    c = 0;
    do begin
      @(posedge clk_i);
      if (clear_flags_o === 1'h1) c++;
      if (vec_done_o === 1'h1) begin
        chk_vec(vec_type_o, x[8*k +: 8]);
        chk_reg({22'h0, vec_addr_o}, {22'h0, x[8*k +: 8], 2'h0});
        last_t = x[8*k +: 8];
        k++;
      end
    end while (busy_o === 1'h1);
    chk_reg(k, {29'h0, x[42:40]});
    chk_reg(c, {29'h0, x[42:40]});
    if (k > 0) begin
      chk_vec({7'h0, ret_to_wait_o}, {7'h0, blk[4]});
      chk_vec({7'h0, ret_one_prefix_o}, {7'h0, blk[3]});
    end
    cnt_exp += k;
  endtask : run

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {boundary_i, seg_load_i, str_iter_i, wait_instr_i, numerics_busy_i, hold_i} = '0;
    {exc_req_i, exc_soft_i, exc_type_i, trap_flag_i, int_enable_i, nmi_pin_i} = '0;
    {raise, slow, mtype, nmi_left, last_t} = '0;
    {fail_count, check_count, cnt_exp, cyc} = '0;
    lf = 32'hf61480ae;
    lf_s = 32'hf61480ae;
    rst_i = 1'h1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 5; i++) begin
      wb(1'h0, adrs[i], 4'hf, 32'h0);
      chk_reg(rd, i == 0 ? {30'h0, irq_core_pkg::CTRL_RESET} : 32'h0);
    end
    wb(1'h1, irq_core_pkg::CTRL_OFS, 4'he, 32'h0);
    wb(1'h0, irq_core_pkg::CTRL_OFS, 4'hf, 32'h0);
    chk_reg(rd, 32'h1);
    wb(1'h1, irq_core_pkg::CTRL_OFS, 4'hf, 32'h0);
    wb(1'h0, irq_core_pkg::CTRL_OFS, 4'hf, 32'h0);
    chk_reg(rd, 32'h0);
    // Software traps with enable clear: ends of range, an NMI type, random
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      run(1'h1, 1'h0, 1'h0, 1'h0, i == 0 ? 8'h00 : i == 1 ? 8'hff : i == 2 ? 8'h02 : lf[7:0],
        8'h00, 5'h00);
    end
    wb(1'h0, irq_core_pkg::STATUS_OFS, 4'hf, 32'h0);
    chk_reg({31'h0, rd[1]}, 32'h0);
    wb(1'h1, irq_core_pkg::CTRL_OFS, 4'hf, 32'h1);
    lf = lfsr(lf);
    run(1'h0, 1'h1, 1'h0, 1'h0, 8'h00, 8'h00, 5'h00);
    run(1'h1, 1'h1, 1'h1, 1'h1, 8'h05, lf[15:8], 5'h00);
    run(1'h0, 1'h0, 1'h0, 1'h0, 8'h00, 8'h00, 5'h00);
    run(1'h0, 1'h0, 1'h1, 1'h0, 8'h00, lf[23:16], 5'h00);
    run(1'h0, 1'h0, 1'h0, 1'h1, 8'h00, 8'h00, 5'h00);
    run(1'h1, 1'h0, 1'h0, 1'h0, 8'h21, 8'h00, 5'h04);
    run(1'h1, 1'h0, 1'h0, 1'h0, 8'h22, 8'h00, 5'h02);
    run(1'h0, 1'h1, 1'h0, 1'h0, 8'h00, 8'h00, 5'h01);
    run(1'h0, 1'h0, 1'h0, 1'h0, 8'h00, 8'h00, 5'h00);
    run(1'h1, 1'h0, 1'h0, 1'h0, 8'h23, 8'h00, 5'h10);
    run(1'h1, 1'h0, 1'h0, 1'h0, 8'h24, 8'h00, 5'h08);
    wb(1'h0, irq_core_pkg::COUNT_OFS, 4'hf, 32'h0);
    chk_reg({16'h0, rd[15:0]}, cnt_exp);
    wb(1'h0, irq_core_pkg::LAST_OFS, 4'hf, 32'h0);
    chk_vec(rd[7:0], last_t);
    end_sim();
  end
endmodule : tb_irq_core
